// ### pfaau_pkg.sv
package pfaau_pkg;

    // Instruction field positions.
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int SRC1_HI = 25;
    localparam int SRC1_LO = 21;
    localparam int SUB_HI = 10;
    localparam int SUB_LO = 6;
    localparam int FN_HI = 5;
    localparam int FN_LO = 0;

    // Encodings of the shared major opcode, the function classes and the sub-operations.
    localparam logic [5:0] EXTENSION_MAJOR_OPCODE = 6'h1F;
    localparam logic [5:0] ABS_CLASS_FUNCTION = 6'h12;
    localparam logic [5:0] ADD_CLASS_FUNCTION = 6'h10;
    localparam logic [4:0] SUB_SAT_ABS_PAIR_HALF = 5'h09;
    localparam logic [4:0] SUB_SAT_ABS_QUAD_BYTE = 5'h01;
    localparam logic [4:0] SUB_SAT_ABS_WORD = 5'h11;
    localparam logic [4:0] SUB_WRAP_ADD_PAIR_HALF = 5'h0A;
    localparam logic [4:0] SUB_SAT_ADD_PAIR_HALF = 5'h0E;
    localparam logic [4:0] ZERO_FIELD = 5'h00;

    // Control register layout and reset value.
    localparam int OVF_FLAG_BIT = 20;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Saturation limits.
    localparam logic [7:0] BYTE_MIN = 8'h80;
    localparam logic [7:0] BYTE_MAX = 8'h7F;
    localparam logic [15:0] HALF_MIN = 16'h8000;
    localparam logic [15:0] HALF_MAX = 16'h7FFF;
    localparam logic [31:0] WORD_MIN = 32'h8000_0000;
    localparam logic [31:0] WORD_MAX = 32'h7FFF_FFFF;

    typedef enum logic [2:0] {
        op_none,
        op_sat_abs_pair_half,
        op_sat_abs_quad_byte,
        op_sat_abs_word,
        op_wrap_add_pair_half,
        op_sat_add_pair_half
    } pfaau_op_t;

endpackage

// ### pfaau_op_if.sv
`timescale 1ns/10ps
interface pfaau_op_if;
    import pfaau_pkg::*;
    logic [31:0] instr;
    pfaau_op_t op;
    modport dec (input instr, output op);
    modport exe (output instr, input op);
endinterface

// ### pfaau_decode.sv
`timescale 1ns/10ps
module pfaau_decode
    import pfaau_pkg::*;
(
    // Instruction in, operation out
    pfaau_op_if.dec opif
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic pfaau_op_t decode_op(input logic [31:0] w);
        pfaau_op_t op;
        op = op_none;
        if (w[OPC_HI:OPC_LO] == EXTENSION_MAJOR_OPCODE) begin
            // The absolute-value forms have no first source, so a nonzero field there is not ours.
            if (w[FN_HI:FN_LO] == ABS_CLASS_FUNCTION && w[SRC1_HI:SRC1_LO] == ZERO_FIELD) begin
                unique case (w[SUB_HI:SUB_LO])
                    SUB_SAT_ABS_PAIR_HALF: op = op_sat_abs_pair_half; // RULE2
                    SUB_SAT_ABS_QUAD_BYTE: op = op_sat_abs_quad_byte; // RULE3
                    SUB_SAT_ABS_WORD: op = op_sat_abs_word; // RULE4
                    default: op = op_none;
                endcase
            end else if (w[FN_HI:FN_LO] == ADD_CLASS_FUNCTION) begin
                unique case (w[SUB_HI:SUB_LO])
                    SUB_WRAP_ADD_PAIR_HALF: op = op_wrap_add_pair_half; // RULE14
                    SUB_SAT_ADD_PAIR_HALF: op = op_sat_add_pair_half; // RULE14
                    default: op = op_none;
                endcase
            end
        end
        return op;
    endfunction

    assign opif.op = decode_op(opif.instr);

endmodule

// ### pfaau_ctrl_reg.sv
`timescale 1ns/10ps
module pfaau_ctrl_reg
    import pfaau_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Software rewrite and flag event
    input wire logic sw_wr_in,
    input wire logic [31:0] sw_wdata_in,
    input wire logic set_flag_in,
    // Register contents
    output logic [31:0] ctrl_out
);

    typedef struct packed {
        logic [31:0] ctrl;
    } pfaau_ctrl_state_t;

    pfaau_ctrl_state_t st;
    pfaau_ctrl_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        if (sw_wr_in) begin
            next_st.ctrl = sw_wdata_in;
        end
        // The flag is set here or by a rewrite with bit 20 high; a set in the rewrite cycle wins so no event is lost.
        if (set_flag_in) begin
            next_st.ctrl[OVF_FLAG_BIT] = 1'b1; // RULE17
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st.ctrl <= CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign ctrl_out = st.ctrl;

endmodule

// ### pfaau_unit.sv
`timescale 1ns/10ps
// Contract
// RULE1: Every listed operation is executed for every element format, no subset.
// RULE2: Pair-half absolute decodes from major 011111, zero source, sub 01001, function 010010.
// RULE3: Quad-byte absolute decodes with sub 00001 under the same opcode and function.
// RULE4: Word absolute decodes with sub 10001 under the same opcode and function.
// RULE5: Halfword absolute negates negatives; 0x8000 yields 0x7FFF.
// RULE6: Byte absolute of four lower bytes; 0x80 saturates to 0x7F.
// RULE7: Word absolute; 0x80000000 saturates to largest positive, then sign extends.
// RULE8: Absolute operations ignore the upper 32 source bits.
// RULE9: Upper 32 result bits copy the sign of the top element result.
// RULE10: Any absolute element saturation sets control bit 20.
// RULE11: Wrapping halfword add writes the two's-complement wrapped sums.
// RULE12: Saturating halfword add clamps to 0x7FFF or 0x8000.
// RULE13: Any halfword add overflow or saturation sets control bit 20.
// RULE14: Halfword adds decode from major 011111, function 010000, sub selects mode.
// RULE15: No exception depends on operand data.
// RULE16: Only reserved-instruction and extension-disabled exceptions are raised.
// RULE17: The flag is only set by these operations, cleared only by software rewrite. A rewrite with bit 20 high also sets it here.
module pfaau_unit
    import pfaau_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Issue from the pipeline
    input wire logic issue_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [63:0] first_source_reg_in,
    input wire logic [63:0] second_source_reg_in,
    input wire logic ext_enable_in,
    // Software rewrite of the control register
    input wire logic ctrl_wr_in,
    input wire logic [31:0] ctrl_wdata_in,
    // Results and exceptions
    output logic result_valid_out,
    output logic [63:0] result_out,
    output logic exc_reserved_out,
    output logic exc_disabled_out,
    output logic [31:0] extension_control_reg_out
);

    typedef struct packed {
        logic [63:0] result;
        logic valid;
        logic exc_ri;
        logic exc_dis;
    } pfaau_state_t;

    pfaau_state_t st;
    pfaau_state_t next_st;

    pfaau_op_if opif();

    logic [31:0] a_lo;
    logic [31:0] b_lo;
    logic [7:0] byte_abs [4];
    logic [3:0] byte_sat;
    logic [15:0] half_abs [2];
    logic [1:0] half_sat;
    logic [15:0] half_wrap [2];
    logic [15:0] half_clamp [2];
    logic [1:0] half_ovf;
    logic [31:0] word_abs;
    logic word_sat;
    logic [31:0] lane_res;
    logic lane_ovf;
    logic set_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode and control register.

    assign opif.instr = instr_in;

    pfaau_decode u_decode (
        .opif(opif.dec)
    );

    pfaau_ctrl_reg u_ctrl (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .sw_wr_in(ctrl_wr_in),
        .sw_wdata_in(ctrl_wdata_in),
        .set_flag_in(set_flag),
        .ctrl_out(extension_control_reg_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Element lanes. Only the lower words are taken, so upper bits cannot leak in.

    assign a_lo = first_source_reg_in[31:0]; // RULE8
    assign b_lo = second_source_reg_in[31:0]; // RULE8

    for (genvar i = 0; i < 4; i++) begin : g_byte
        logic [7:0] v;
        assign v = b_lo[8*i +: 8];
        assign byte_sat[i] = (v == BYTE_MIN); // RULE6
        assign byte_abs[i] = byte_sat[i] ? BYTE_MAX : (v[7] ? -v : v); // RULE6
    end

    for (genvar i = 0; i < 2; i++) begin : g_half
        logic [15:0] v;
        logic [15:0] x;
        logic [16:0] sum;
        assign v = b_lo[16*i +: 16];
        assign x = a_lo[16*i +: 16];
        assign half_sat[i] = (v == HALF_MIN); // RULE5
        assign half_abs[i] = half_sat[i] ? HALF_MAX : (v[15] ? -v : v); // RULE5
        assign sum = {x[15], x} + {v[15], v};
        assign half_ovf[i] = sum[16] ^ sum[15]; // RULE13
        assign half_wrap[i] = sum[15:0]; // RULE11
        assign half_clamp[i] = half_ovf[i] ? (sum[16] ? HALF_MIN : HALF_MAX) : sum[15:0]; // RULE12
    end

    assign word_sat = (b_lo == WORD_MIN); // RULE7
    assign word_abs = word_sat ? WORD_MAX : (b_lo[31] ? -b_lo : b_lo); // RULE7

    // Every decoded form has its own lane result; nothing is left unimplemented.
    always_comb begin
        lane_res = 32'h0000_0000;
        lane_ovf = 1'b0;
        unique case (opif.op) // RULE1
            op_sat_abs_pair_half: begin
                lane_res = {half_abs[1], half_abs[0]};
                lane_ovf = |half_sat; // RULE10
            end
            op_sat_abs_quad_byte: begin
                lane_res = {byte_abs[3], byte_abs[2], byte_abs[1], byte_abs[0]};
                lane_ovf = |byte_sat; // RULE10
            end
            op_sat_abs_word: begin
                lane_res = word_abs;
                lane_ovf = word_sat; // RULE10
            end
            op_wrap_add_pair_half: begin
                lane_res = {half_wrap[1], half_wrap[0]};
                lane_ovf = |half_ovf; // RULE13
            end
            op_sat_add_pair_half: begin
                lane_res = {half_clamp[1], half_clamp[0]};
                lane_ovf = |half_ovf; // RULE13
            end
            op_none: begin
                lane_res = 32'h0000_0000;
                lane_ovf = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Issue, exceptions and result register.

    // Exceptions come only from the encoding and the enable, never from the operands.
    always_comb begin
        next_st = st;
        next_st.valid = 1'b0;
        next_st.exc_ri = 1'b0;
        next_st.exc_dis = 1'b0;
        set_flag = 1'b0;
        if (issue_valid_in) begin
            if (opif.op == op_none) begin
                next_st.exc_ri = 1'b1; // RULE16
            end else if (!ext_enable_in) begin
                next_st.exc_dis = 1'b1; // RULE16
            end else begin
                next_st.valid = 1'b1; // RULE15
                next_st.result = {{32{lane_res[31]}}, lane_res}; // RULE9
                set_flag = lane_ovf; // RULE10 RULE13
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            st.result <= 64'h0000_0000_0000_0000;
            st.valid <= 1'b0;
            st.exc_ri <= 1'b0;
            st.exc_dis <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign result_valid_out = st.valid;
    assign result_out = st.result;
    assign exc_reserved_out = st.exc_ri;
    assign exc_disabled_out = st.exc_dis;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic go;
    assign go = issue_valid_in && ext_enable_in && (opif.op != op_none);

    half_sat_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE5
        go && opif.op == op_sat_abs_pair_half && second_source_reg_in[15:0] == 16'h8000
        |=> result_valid_out && result_out[15:0] == 16'h7FFF && extension_control_reg_out[20])
        else $error("Halfword minimum did not saturate.");

    byte_sat_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE6
        go && opif.op == op_sat_abs_quad_byte && second_source_reg_in[31:24] == 8'h80
        |=> result_out[31:24] == 8'h7F && result_out[63:32] == 32'h0000_0000)
        else $error("Byte minimum did not saturate.");

    word_sat_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE7
        go && opif.op == op_sat_abs_word && second_source_reg_in[31:0] == 32'h8000_0000
        |=> result_out == 64'h0000_0000_7FFF_FFFF)
        else $error("Word minimum did not saturate.");

    abs_upper_ignored_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE8
        go && opif.op == op_sat_abs_word && !second_source_reg_in[31]
        |=> result_out[31:0] == $past(second_source_reg_in[31:0]))
        else $error("Word absolute of a positive value changed it.");

    sign_extend_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE9
        result_valid_out |-> result_out[63:32] == {32{result_out[31]}})
        else $error("Upper result word is not a sign copy.");

    wrap_add_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE11
        go && opif.op == op_wrap_add_pair_half
        |=> result_out[15:0] == 16'($past(first_source_reg_in[15:0]) + $past(second_source_reg_in[15:0])))
        else $error("Wrapping add lane 0 is wrong.");

    sat_add_pos_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE12
        go && opif.op == op_sat_add_pair_half
        && first_source_reg_in[31:16] == 16'h7FFF && second_source_reg_in[31:16] == 16'h0001
        |=> result_out[31:16] == 16'h7FFF && result_out[63:32] == 32'h0000_0000)
        else $error("Saturating add did not clamp high.");

    add_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE13
        go && (opif.op == op_wrap_add_pair_half || opif.op == op_sat_add_pair_half) && |half_ovf
        |=> extension_control_reg_out[20])
        else $error("Add overflow did not set the flag.");

    flag_sticky_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE17
        extension_control_reg_out[20] && !ctrl_wr_in |=> extension_control_reg_out[20])
        else $error("Flag cleared without a rewrite.");

    no_data_exc_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE15
        go |=> result_valid_out && !exc_reserved_out && !exc_disabled_out)
        else $error("Valid enabled operation raised an exception.");

    // Back-to-back refused issues are legal, so the one-cycle pulse is checked from the idle side.
    disabled_exc_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE16
        issue_valid_in && !ext_enable_in && opif.op != op_none
        |=> exc_disabled_out && !result_valid_out && !exc_reserved_out)
        else $error("Disabled extension not reported.");

    disabled_pulse_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE16
        !(issue_valid_in && !ext_enable_in && opif.op != op_none) |=> !exc_disabled_out)
        else $error("Disabled exception stood without a disabled issue.");

    reserved_exc_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE16
        issue_valid_in && opif.op == op_none |=> exc_reserved_out && !result_valid_out && !exc_disabled_out)
        else $error("Undecodable word not reported as reserved.");

    one_answer_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE16
        $onehot0({result_valid_out, exc_reserved_out, exc_disabled_out}))
        else $error("More than one answer raised at once.");

    refused_result_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE16
        issue_valid_in && !go |=> $stable(result_out) && !result_valid_out)
        else $error("Refused issue changed the result.");

    refused_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE17
        issue_valid_in && !go && !ctrl_wr_in
        |=> extension_control_reg_out == $past(extension_control_reg_out))
        else $error("Refused issue changed the control register.");

    ctrl_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE17
        ctrl_wr_in && !go
        |=> extension_control_reg_out == $past(ctrl_wdata_in))
        else $error("Control register rewrite did not land.");

    quad_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE10
        go && opif.op == op_sat_abs_quad_byte && second_source_reg_in[7:0] == BYTE_MIN
        |=> extension_control_reg_out[OVF_FLAG_BIT])
        else $error("Byte saturation did not set the flag.");

    word_flag_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE10
        go && opif.op == op_sat_abs_word && second_source_reg_in[31:0] == WORD_MIN
        |=> extension_control_reg_out[OVF_FLAG_BIT])
        else $error("Word saturation did not set the flag.");

    word_neg_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE7
        go && opif.op == op_sat_abs_word && second_source_reg_in[31:0] == 32'h8000_8000
        |=> result_out == 64'h0000_0000_7FFF_8000)
        else $error("Word absolute of a negative value is wrong.");

    half_pos_pass_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE5
        go && opif.op == op_sat_abs_pair_half && !second_source_reg_in[15]
        |=> result_out[15:0] == $past(second_source_reg_in[15:0]))
        else $error("Non-negative halfword was not passed unchanged.");

    sat_add_neg_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RULE12
        go && opif.op == op_sat_add_pair_half
        && first_source_reg_in[15:0] == HALF_MIN && second_source_reg_in[15:0] == HALF_MIN
        |=> result_out[15:0] == HALF_MIN)
        else $error("Saturating add did not clamp low.");

    abs_half_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        go && opif.op == op_sat_abs_pair_half && |half_sat);

    sat_add_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        go && opif.op == op_sat_add_pair_half && half_ovf == 2'b11);

    reserved_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        issue_valid_in && opif.op == op_none ##1 exc_reserved_out);

    rewrite_race_cov: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
        ctrl_wr_in && set_flag);

endmodule

// ### pfaau_host_model.sv
`timescale 1ns/10ps
module pfaau_host_model (
    // Clock
    input wire logic mclk_in,
    // Issue toward the unit
    output logic issue_valid_out,
    output logic [31:0] instr_out,
    output logic [63:0] first_source_out,
    output logic [63:0] second_source_out,
    output logic ext_enable_out,
    // Software rewrite of the control register
    output logic ctrl_wr_out,
    output logic [31:0] ctrl_wdata_out
);
    initial begin
        issue_valid_out = 1'b0;
        instr_out = 32'h0;
        first_source_out = 64'h0;
        second_source_out = 64'h0;
        ext_enable_out = 1'b1;
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Every change lands on the falling edge, so the unit samples settled values.
    task automatic put(input logic v, input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b,
                       input logic en, input logic wr, input logic [31:0] wd);
        @(negedge mclk_in);
        issue_valid_out = v;
        instr_out = ins;
        first_source_out = a;
        second_source_out = b;
        ext_enable_out = en;
        ctrl_wr_out = wr;
        ctrl_wdata_out = wd;
    endtask

    // An idle pipeline scrambles its operand lines rather than holding the last issue.
    task automatic rest();
        @(negedge mclk_in);
        issue_valid_out = 1'b0;
        instr_out = ~instr_out;
        first_source_out = ~first_source_out;
        second_source_out = ~second_source_out;
        ctrl_wr_out = 1'b0;
        ctrl_wdata_out = ~ctrl_wdata_out;
    endtask
endmodule

// ### packed_fraction_abs_add_unit_test.sv
`timescale 1ns/10ps
module packed_fraction_abs_add_unit_test
    import pfaau_pkg::*;
;
    typedef struct {logic [2:0] kind; logic [63:0] res; logic [31:0] ctrl;} pfaau_note_t;
    logic mclk_in;
    logic rst_n_in;
    logic issue_valid;
    logic [31:0] instr;
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic ext_en;
    logic ctrl_wr;
    logic [31:0] ctrl_wdata;
    logic result_valid_out;
    logic [63:0] result_out;
    logic exc_reserved_out;
    logic exc_disabled_out;
    logic [31:0] extension_control_reg_out;
    pfaau_note_t notes[$];
    logic [31:0] exp_ctrl;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    pfaau_host_model host (.mclk_in(mclk_in), .issue_valid_out(issue_valid), .instr_out(instr),
        .first_source_out(src_a), .second_source_out(src_b), .ext_enable_out(ext_en),
        .ctrl_wr_out(ctrl_wr), .ctrl_wdata_out(ctrl_wdata));

    pfaau_unit uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .issue_valid_in(issue_valid), .instr_in(instr),
        .first_source_reg_in(src_a), .second_source_reg_in(src_b), .ext_enable_in(ext_en),
        .ctrl_wr_in(ctrl_wr), .ctrl_wdata_in(ctrl_wdata), .result_valid_out(result_valid_out),
        .result_out(result_out), .exc_reserved_out(exc_reserved_out), .exc_disabled_out(exc_disabled_out),
        .extension_control_reg_out(extension_control_reg_out));

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Boundary lanes are favoured, since random words rarely hit the saturation points.
    function automatic logic [63:0] pick();
        logic [63:0] v;
        v = {$urandom, $urandom};
        case ($urandom % 5)
            0: v[31:0] = 32'h8000_8000;
            1: v[31:0] = 32'h8080_7F01;
            2: v[31:0] = 32'h7FFF_8001;
            default: ;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Kind k: 0..4 the five operations, 5 and 6 undecodable words, below 0 no issue.
    task automatic issue(input int k, input logic [63:0] a, input logic [63:0] b, input logic en,
                         input logic wr, input logic [31:0] wd);
        logic [31:0] rnd;
        logic [31:0] r;
        logic [31:0] ins;
        logic [16:0] s;
        logic [15:0] h;
        logic [7:0] y;
        logic f;
        pfaau_note_t n;
        rnd = $urandom;
        r = 32'h0;
        f = 1'b0;
        ins = {EXTENSION_MAJOR_OPCODE, 5'h00, rnd[20:11], SUB_SAT_ABS_PAIR_HALF, ABS_CLASS_FUNCTION};
        case (k)
            0: for (int i = 0; i < 2; i++) begin
                h = b[16*i+:16];
                f |= (h == 16'h8000);
                r[16*i+:16] = (h == 16'h8000) ? 16'h7FFF : (h[15] ? -h : h);
            end
            1: begin
                ins[10:6] = SUB_SAT_ABS_QUAD_BYTE;
                for (int i = 0; i < 4; i++) begin
                    y = b[8*i+:8];
                    f |= (y == 8'h80);
                    r[8*i+:8] = (y == 8'h80) ? 8'h7F : (y[7] ? -y : y);
                end
            end
            2: begin
                ins[10:6] = SUB_SAT_ABS_WORD;
                f = (b[31:0] == 32'h8000_0000);
                r = f ? 32'h7FFF_FFFF : (b[31] ? -b[31:0] : b[31:0]);
            end
            3, 4: begin
                ins = {EXTENSION_MAJOR_OPCODE, rnd[25:11], (k == 4) ? SUB_SAT_ADD_PAIR_HALF : SUB_WRAP_ADD_PAIR_HALF,
                       ADD_CLASS_FUNCTION};
                for (int i = 0; i < 2; i++) begin
                    s = {a[16*i+15], a[16*i+:16]} + {b[16*i+15], b[16*i+:16]};
                    f |= s[16] ^ s[15];
                    r[16*i+:16] = (k == 4 && (s[16] ^ s[15])) ? (s[16] ? 16'h8000 : 16'h7FFF) : s[15:0];
                end
            end
            5: ins[25:21] = rnd[25:21] | 5'h01;
            6: ins[31:26] = 6'h00;
            default: ;
        endcase
        host.put(k >= 0, ins, a, b, en, wr, wd);
        n.ctrl = wr ? wd : exp_ctrl;
        n.kind = (k >= 5) ? 3'b010 : (en ? 3'b100 : 3'b001);
        if (n.kind == 3'b100 && f)
            n.ctrl[20] = 1'b1;
        n.res = {{32{r[31]}}, r};
        exp_ctrl = n.ctrl;
        if (k >= 0)
            notes.push_back(n);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge mclk_in) begin
        pfaau_note_t n;
        if ((result_valid_out | exc_reserved_out | exc_disabled_out) === 1'b1) begin
            if (notes.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                n = notes.pop_front();
                check({result_valid_out, exc_reserved_out, exc_disabled_out}, n.kind);
                if (n.kind == 3'b100)
                    check(result_out, n.res);
                check(extension_control_reg_out, n.ctrl);
            end
        end
    end

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        void'($urandom(32'h45B92139));
        rst_n_in = 1'b0;
        exp_ctrl = 32'h0;
        repeat (4) @(posedge mclk_in);
        @(negedge mclk_in);
        check(extension_control_reg_out, 64'h0);
        check({result_valid_out, exc_reserved_out, exc_disabled_out}, 64'h0);
        rst_n_in = 1'b1;
        // The hand-over walk, with junk in the upper word that must be ignored.
        issue(0, pick(), {32'hA5A5_5A5A, 32'h8000_0005}, 1'b1, 1'b0, 32'h0);
        issue(-1, 64'h0, 64'h0, 1'b1, 1'b1, 32'h0);
        // Each operation twice back to back: once on a boundary (word absolute excepted), once quiet.
        for (int k = 0; k < 5; k++) begin
            issue(k, 64'h0000_0000_7FFF_8000, 64'hFFFF_FFFF_8080_8000, 1'b1, 1'b0, 32'h0);
            issue(k, 64'h0, 64'h0000_0000_0001_0002, 1'b1, 1'b1, 32'h0);
        end
        // A rewrite clearing the flag in the cycle a saturating op sets it: the set wins.
        issue(2, 64'h0, 64'h0000_0000_8000_0000, 1'b1, 1'b1, 32'h1224_5678);
        issue(5, pick(), pick(), 1'b0, 1'b0, 32'h0);
        issue(6, pick(), pick(), 1'b1, 1'b0, 32'h0);
        issue(0, pick(), 64'h0000_0000_8000_8000, 1'b0, 1'b0, 32'h0);
        for (int i = 0; i < 400; i++)
            issue(int'($urandom % 8) - 1, pick(), pick(), ($urandom % 8) != 0, ($urandom % 6) == 0,
                  $urandom);
        host.rest();
        repeat (3) @(negedge mclk_in);
        check(notes.size(), 64'h0);
        close_out();
    end
endmodule
